//--- verilog/tcp_pkg.sv
package tcp_pkg;

   // ==========================================================
   // Register map (word index on the register port).
   localparam logic [3:0] ADDR_CTRL    = 4'h0;
   localparam logic [3:0] ADDR_OPTION  = 4'h1;
   localparam logic [3:0] ADDR_EDGE    = 4'h2;
   localparam logic [3:0] ADDR_DIV     = 4'h3;
   localparam logic [3:0] ADDR_COUNT   = 4'h4;
   localparam logic [3:0] ADDR_CCR0    = 4'h8;
   localparam logic [3:0] ADDR_ISTAT   = 4'hC;
   localparam logic [3:0] ADDR_IMASK   = 4'hD;

   // ==========================================================
   // Field positions.
   localparam int CTRL_RUN_BIT  = 7;
   localparam int OPT_OVF_BIT   = 0;
   localparam int OPT_CCS_LSB   = 4;
   localparam int ISTAT_OVF_BIT = 4;

   // ==========================================================
   // Codes, reset values and counts.
   localparam logic [2:0]  MODE_FREE_RUN  = 3'h5;
   localparam logic [2:0]  MODE_PULSE_W   = 3'h6;
   localparam logic [1:0]  EDGE_NONE      = 2'h0;
   localparam logic [1:0]  EDGE_RISE      = 2'h1;
   localparam logic [1:0]  EDGE_FALL      = 2'h2;
   localparam logic [1:0]  EDGE_BOTH      = 2'h3;
   localparam logic [15:0] CNT_MAX        = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO       = 16'h0000;
   localparam logic [15:0] RST_REG        = 16'h0000;
   localparam logic [7:0]  RST_DIV        = 8'h00;
   localparam int          NUM_CH         = 4;

   typedef enum logic [1:0] {
      TCP_IDLE  = 2'b00,
      TCP_ARMED = 2'b01,
      TCP_RUN   = 2'b11
   } tcp_state_t;

   typedef struct packed {
      logic       run;
      logic [2:0] mode;
   } tcp_ctrl_t;

   typedef struct packed {
      logic       ovf;
      logic [3:0] cc;
   } tcp_evt_t;

endpackage

//--- verilog/tcp_edge_det.sv
`timescale 1ns/1ns
module tcp_edge_det
   import tcp_pkg::*;
(
   input  wire logic       ref_clk_in,   // System clock.
   input  wire logic       srst_in,      // Synchronous reset.
   input  wire logic       trig_in,      // Raw capture trigger.
   input  wire logic [1:0] sel_in,       // Edge selection.
   output logic            edge_out      // One-cycle edge pulse.
);

   logic [2:0] sync;
   logic [2:0] next_sync;
   logic       next_edge;
   logic       rise;
   logic       fall;

   // ==========================================================
   // Two-flop synchroniser, then a history flop for edges.
   always_comb begin
      next_sync = {sync[1:0], trig_in};
      rise      = sync[1] & ~sync[2];
      fall      = ~sync[1] & sync[2];
      case (sel_in)
         EDGE_RISE: next_edge = rise;
         EDGE_FALL: next_edge = fall;
         EDGE_BOTH: next_edge = rise | fall;
         default:   next_edge = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         sync     <= 3'h0;
         edge_out <= 1'b0;
      end else begin
         sync     <= next_sync;
         edge_out <= next_edge;
      end
   end

endmodule

//--- verilog/tcp_timer.sv
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
// Functional notes
// - Mode code 110 selects pulse width measurement.
// - Counter counts once run enable set in mode 101 or 110.
// - Edge captures counter and interrupts; clears it in mode 110 only.
// - Overflow interrupt after FFFFH, counter wraps.
// - Overflow sets sticky option flag.
// - Flag cleared by writing bit 0 low.
// - Early capture after start may read FFFFH.
// - One overflow flag shared by all channels.
// - Mode 101 is free running, wrapping.
// - Select bit makes channel capture or compare.
// - Compare match interrupts and toggles output.
module tcp_timer
   import tcp_pkg::*;
(
   input  wire logic        ref_clk_in,     // 100 MHz clock.
   input  wire logic        srst_in,        // Synchronous reset, high.
   input  wire logic [3:0]  addr_in,        // Register index.
   input  wire logic [15:0] wdata_in,       // Write data.
   input  wire logic        wr_in,          // Write strobe.
   input  wire logic        rd_in,          // Read strobe.
   input  wire logic [3:0]  trig_in,        // Capture trigger inputs.
   output logic      [15:0] rdata_out,      // Read data, cycle after read.
   output logic      [3:0]  cc_irq_out,     // Match/capture pulses.
   output logic             ovf_irq_out,    // Overflow pulse.
   output logic      [3:0]  tout_out,       // Timer output pins.
   output logic             irq_out         // Combined level interrupt.
);

   tcp_ctrl_t   ctrl;
   logic [7:0]  option;
   logic [7:0]  edge_sel;
   logic [7:0]  div;
   logic [7:0]  pre;
   logic [15:0] cnt;
   logic [15:0] ccr [NUM_CH];
   tcp_evt_t    istat;
   tcp_evt_t    imask;
   tcp_state_t  state;
   logic [3:0]  edges;

   tcp_ctrl_t   next_ctrl;
   logic [7:0]  next_option;
   logic [7:0]  next_edge_sel;
   logic [7:0]  next_div;
   logic [7:0]  next_pre;
   logic [15:0] next_cnt;
   logic [15:0] next_ccr [NUM_CH];
   tcp_evt_t    next_istat;
   tcp_evt_t    next_imask;
   tcp_state_t  next_state;
   logic [15:0] next_rdata;
   logic [3:0]  next_cc_irq;
   logic        next_ovf_irq;
   logic [3:0]  next_tout;
   logic        next_irq;

   logic        tick;
   logic        active;
   logic        pw_mode;
   logic        fr_mode;
   logic        ovf_evt;
   logic [3:0]  cap_evt;
   logic [3:0]  cmp_evt;

   function automatic logic is_wr(input logic [3:0] a, input logic [3:0] r);
      is_wr = wr_in && (a == r);
   endfunction

   // ==========================================================
   // Synchronised edge detectors, one per trigger input.
   for (genvar g = 0; g < NUM_CH; g++) begin : g_edge
      tcp_edge_det u_edge (
         .ref_clk_in (ref_clk_in),
         .srst_in    (srst_in),
         .trig_in    (trig_in[g]),
         .sel_in     (edge_sel[2*g +: 2]),
         .edge_out   (edges[g])
      );
   end

   // ==========================================================
   // Count clock enable from the prescaler.
   always_comb begin
      // Lowering the divider below the prescaler must not stall the count clock.
      tick     = (pre >= div);
      next_pre = tick ? 8'h00 : pre + 8'h01;
   end

   // ==========================================================
   // Counter, captures, compares and overflow.
   always_comb begin
      pw_mode    = ctrl.run && (ctrl.mode == MODE_PULSE_W);
      fr_mode    = ctrl.run && (ctrl.mode == MODE_FREE_RUN);
      active     = pw_mode | fr_mode;
      next_state = state;
      next_cnt   = cnt;
      ovf_evt    = 1'b0;
      cap_evt    = 4'h0;
      cmp_evt    = 4'h0;
      for (int m = 0; m < NUM_CH; m++) begin
         next_ccr[m] = ccr[m];
         if (is_wr(addr_in, ADDR_CCR0 + 4'(m))) begin
            next_ccr[m] = wdata_in;
         end
      end
      case (state)
         TCP_IDLE: begin
            next_cnt = CNT_MAX;
            if (active) begin
               next_state = TCP_ARMED;
            end
         end
         TCP_ARMED: begin
            // Counter still reads FFFFH until the first count clock or a mode 110 capture.
            if (!active) begin
               next_state = TCP_IDLE;
            end else if (tick) begin
               next_cnt   = CNT_ZERO;
               next_state = TCP_RUN;
            end
         end
         TCP_RUN: begin
            if (!active) begin
               next_state = TCP_IDLE;
            end else if (tick) begin
               next_cnt = cnt + 16'h0001;
               if (cnt == CNT_MAX) begin
                  ovf_evt = 1'b1;
               end
            end
         end
         default: begin
            next_state = TCP_IDLE;
         end
      endcase
      for (int m = 0; m < NUM_CH; m++) begin
         if (state != TCP_IDLE && active) begin
            if (option[OPT_CCS_LSB + m] || pw_mode) begin
               if (edges[m]) begin
                  cap_evt[m]  = 1'b1;
                  next_ccr[m] = cnt;
               end
            end else if (fr_mode && state == TCP_RUN && tick && cnt == ccr[m]) begin
               cmp_evt[m] = 1'b1;
            end
         end
      end
      if (pw_mode && cap_evt != 4'h0) begin
         next_cnt = CNT_ZERO;
      end
   end

   // ==========================================================
   // Registers, interrupt status and read data.
   always_comb begin
      next_ctrl     = ctrl;
      next_option   = option;
      next_edge_sel = edge_sel;
      next_div      = div;
      next_imask    = imask;
      next_istat    = istat;
      next_rdata    = RST_REG;
      next_tout     = tout_out;
      if (is_wr(addr_in, ADDR_CTRL)) begin
         next_ctrl.run  = wdata_in[CTRL_RUN_BIT];
         next_ctrl.mode = wdata_in[2:0];
      end
      if (is_wr(addr_in, ADDR_OPTION)) begin
         next_option[7:OPT_CCS_LSB] = wdata_in[7:OPT_CCS_LSB];
         if (!wdata_in[OPT_OVF_BIT]) begin
            next_option[OPT_OVF_BIT] = 1'b0;
         end
      end
      if (ovf_evt) begin
         next_option[OPT_OVF_BIT] = 1'b1;
      end
      if (is_wr(addr_in, ADDR_EDGE)) begin
         next_edge_sel = wdata_in[7:0];
      end
      if (is_wr(addr_in, ADDR_DIV)) begin
         next_div = wdata_in[7:0];
      end
      if (is_wr(addr_in, ADDR_IMASK)) begin
         next_imask = wdata_in[4:0];
      end
      if (is_wr(addr_in, ADDR_ISTAT)) begin
         next_istat = istat & ~tcp_evt_t'(wdata_in[4:0]);
      end
      next_istat.cc  = next_istat.cc | cap_evt | cmp_evt;
      next_istat.ovf = next_istat.ovf | ovf_evt;
      next_irq       = |(next_istat & next_imask);
      next_cc_irq    = cap_evt | cmp_evt;
      next_ovf_irq   = ovf_evt;
      if (fr_mode && state == TCP_IDLE) begin
         next_tout = ~tout_out;
      end
      next_tout = next_tout ^ cmp_evt;
      if (rd_in) begin
         case (addr_in)
            ADDR_CTRL:    next_rdata = {8'h00, ctrl.run, 4'h0, ctrl.mode};
            ADDR_OPTION:  next_rdata = {8'h00, option};
            ADDR_EDGE:    next_rdata = {8'h00, edge_sel};
            ADDR_DIV:     next_rdata = {8'h00, div};
            ADDR_COUNT:   next_rdata = cnt;
            ADDR_CCR0:    next_rdata = ccr[0];
            ADDR_CCR0 + 4'h1: next_rdata = ccr[1];
            ADDR_CCR0 + 4'h2: next_rdata = ccr[2];
            ADDR_CCR0 + 4'h3: next_rdata = ccr[3];
            ADDR_ISTAT:   next_rdata = {11'h000, istat};
            ADDR_IMASK:   next_rdata = {11'h000, imask};
            default:      next_rdata = RST_REG;
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (srst_in) begin
         ctrl        <= '0;
         option      <= 8'h00;
         edge_sel    <= 8'h00;
         div         <= RST_DIV;
         pre         <= 8'h00;
         cnt         <= CNT_MAX;
         state       <= TCP_IDLE;
         istat       <= '0;
         imask       <= '0;
         rdata_out   <= RST_REG;
         cc_irq_out  <= 4'h0;
         ovf_irq_out <= 1'b0;
         tout_out    <= 4'h0;
         irq_out     <= 1'b0;
         for (int m = 0; m < NUM_CH; m++) begin
            ccr[m] <= RST_REG;
         end
      end else begin
         ctrl        <= next_ctrl;
         option      <= next_option;
         edge_sel    <= next_edge_sel;
         div         <= next_div;
         pre         <= next_pre;
         cnt         <= next_cnt;
         state       <= next_state;
         istat       <= next_istat;
         imask       <= next_imask;
         rdata_out   <= next_rdata;
         cc_irq_out  <= next_cc_irq;
         ovf_irq_out <= next_ovf_irq;
         tout_out    <= next_tout;
         irq_out     <= next_irq;
         for (int m = 0; m < NUM_CH; m++) begin
            ccr[m] <= next_ccr[m];
         end
      end
   end

   // ==========================================================
   // Checks.
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (srst_in);

   chk_pw_clear: assert property (pw_mode && state != TCP_IDLE && edges != 4'h0
      |=> cnt == CNT_ZERO && cc_irq_out == $past(edges))
      else $error("pulse width capture did not clear counter");
   chk_cap_value: assert property (pw_mode && state != TCP_IDLE && edges[0]
      |=> ccr[0] == $past(cnt))
      else $error("capture register missed counter value");
   chk_ovf_pulse: assert property (state == TCP_RUN && active && tick && cnt == CNT_MAX
      |=> ovf_irq_out && cnt == CNT_ZERO ##1 !ovf_irq_out)
      else $error("overflow pulse or wrap wrong");
   chk_ovf_flag: assert property (ovf_irq_out |-> option[OPT_OVF_BIT])
      else $error("overflow flag not set");
   chk_ovf_sticky: assert property (option[OPT_OVF_BIT] && !wr_in
      |=> option[OPT_OVF_BIT])
      else $error("overflow flag lost without a write");
   chk_ovf_clear: assert property (wr_in && addr_in == ADDR_OPTION && !wdata_in[0]
      && !ovf_evt |=> !option[OPT_OVF_BIT])
      else $error("overflow flag not cleared");
   chk_start_count: assert property (state == TCP_ARMED && active && tick
      |=> cnt == CNT_ZERO && state == TCP_RUN)
      else $error("counter did not start");
   chk_cmp_toggle: assert property (cmp_evt != 4'h0
      |=> (tout_out ^ $past(tout_out)) == $past(cmp_evt)
      && (cc_irq_out & $past(cmp_evt)) == $past(cmp_evt))
      else $error("compare match did not toggle output");
   chk_mode_idle: assert property (!active |=> state == TCP_IDLE ##1 cnt == CNT_MAX)
      else $error("stopped counter not parked");
   chk_irq_level: assert property (irq_out == |(istat & imask))
      else $error("interrupt level wrong");

   cov_pw_capture: cover property (pw_mode ##1 cap_evt != 4'h0);
   cov_overflow:   cover property (ovf_evt ##[1:100] cap_evt != 4'h0);
   cov_compare:    cover property (fr_mode && cmp_evt != 4'h0);

endmodule

//--- dv/tcp_pulse_src.sv
`timescale 1ns/1ns
// =====================================================================
// External pulse sources on the capture trigger pins.
module tcp_pulse_src (
   input  wire logic       ref_clk_in,   // Clock that paces the pulses.
   output logic      [3:0] trig_out      // Trigger levels, idle low.
);
   initial trig_out = 4'h0;

   // Drives one pulse of hi clocks on a channel, edges just after a clock edge.
   task automatic pulse(input int ch, input int hi);
      @(posedge ref_clk_in);
      trig_out[ch] <= 1'b1;
      repeat (hi) @(posedge ref_clk_in);
      trig_out[ch] <= 1'b0;
   endtask
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ns
// =====================================================================
// Self-checking bench for the capture/compare timer.
module testbench
   import tcp_pkg::*;
;
   logic        ref_clk_in = 1'b0;
   logic        srst_in    = 1'b1;
   logic [3:0]  addr       = 4'h0;
   logic [15:0] wdata      = 16'h0000;
   logic        wr         = 1'b0;
   logic        rd         = 1'b0;
   logic [3:0]  trig;
   logic [15:0] rdata;
   logic [3:0]  cc_irq;
   logic        ovf_irq;
   logic [3:0]  tout;
   logic        irq;
   int          n_tests    = 0;
   int          bad_count  = 0;
   int          n_ovf      = 0;
   int          n_cc[4]    = '{0, 0, 0, 0};
   int          n_cyc      = 0;
   int          last_cc[4] = '{0, 0, 0, 0};

   always #5 ref_clk_in = ~ref_clk_in;

   tcp_timer i_dut (
      .ref_clk_in (ref_clk_in), .srst_in (srst_in), .addr_in (addr), .wdata_in (wdata),
      .wr_in (wr), .rd_in (rd), .trig_in (trig), .rdata_out (rdata),
      .cc_irq_out (cc_irq), .ovf_irq_out (ovf_irq), .tout_out (tout), .irq_out (irq));

   tcp_pulse_src i_src (.ref_clk_in (ref_clk_in), .trig_out (trig));

   // Counts interrupt pulses and stamps the cycle of each channel's latest pulse.
   always @(posedge ref_clk_in) begin
      n_cyc++;
      if (ovf_irq === 1'b1) n_ovf++;
      for (int i = 0; i < 4; i++) begin
         if (cc_irq[i] === 1'b1) begin
            n_cc[i]++;
            last_cc[i] = n_cyc;
         end
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk_in);
      wr <= 1'b1; addr <= a; wdata <= d;
      @(posedge ref_clk_in);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk_in);
      rd <= 1'b1; addr <= a;
      @(posedge ref_clk_in);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic t_reset();
      logic [15:0] d;
      chk(rdata, 16'h0000);
      rd_reg(ADDR_CTRL, d);  chk(d, RST_REG);
      rd_reg(ADDR_COUNT, d); chk(d, CNT_MAX);
      rd_reg(ADDR_ISTAT, d); chk(d, RST_REG);
      wr_reg(4'h5, 16'h1234);
      rd_reg(4'h5, d);       chk(d, 16'h0000);
      $display("test reset done");
   endtask

   task automatic t_pw();
      logic [15:0] d;
      int          c0;
      int          c1;
      wr_reg(ADDR_CTRL, {13'h0, MODE_PULSE_W});
      wr_reg(ADDR_EDGE, {12'h0, EDGE_RISE, EDGE_NONE});
      wr_reg(ADDR_IMASK, 16'h0002);
      wr_reg(ADDR_CTRL, {8'h0, 1'b1, 4'h0, MODE_PULSE_W});
      // The first capture after start may hold FFFF and is not judged.
      i_src.pulse(1, 20);
      repeat (19) @(posedge ref_clk_in);
      c0 = n_cc[1];
      c1 = n_cc[0];
      i_src.pulse(1, 5);
      i_src.pulse(0, 5);
      repeat (6) @(posedge ref_clk_in);
      chk(16'(n_cc[1] - c0), 16'h0001);
      chk(16'(n_cc[0] - c1), 16'h0000);
      rd_reg(ADDR_CCR0 + 4'h1, d);
      chk({15'h0, d == 16'h0027 || d == 16'h0028}, 16'h0001);
      rd_reg(ADDR_COUNT, d);
      chk({15'h0, d < 16'h0020}, 16'h0001);
      rd_reg(ADDR_ISTAT, d); chk(d & 16'h0002, 16'h0002);
      chk({15'h0, irq}, 16'h0001);
      wr_reg(ADDR_ISTAT, 16'h0002);
      @(posedge ref_clk_in);
      #1 chk({15'h0, irq}, 16'h0000);
      $display("test pulse width done");
   endtask

   task automatic t_ovf();
      logic [15:0] d;
      int          c0;
      int          s0;
      int          n_wrap;
      int          w;
      int          n;
      wr_reg(ADDR_CTRL, 16'h0000);
      wr_reg(ADDR_EDGE, {14'h0000, EDGE_RISE});
      wr_reg(ADDR_IMASK, 16'h0010);
      wr_reg(ADDR_CTRL, {8'h0, 1'b1, 4'h0, MODE_PULSE_W});
      // The first capture opens the interval that spans the overflow.
      i_src.pulse(0, 2);
      repeat (6) @(posedge ref_clk_in);
      s0 = last_cc[0];
      c0 = n_ovf;
      for (int i = 0; i < 70000 && n_ovf == c0; i++) @(posedge ref_clk_in);
      repeat (2) @(posedge ref_clk_in);
      chk(16'(n_ovf - c0), 16'h0001);
      rd_reg(ADDR_COUNT, d);
      chk({15'h0, d < 16'h0010}, 16'h0001);
      chk({15'h0, irq}, 16'h0001);
      rd_reg(ADDR_OPTION, d); chk(d & 16'h0001, 16'h0001);
      wr_reg(ADDR_OPTION, 16'h0001);
      rd_reg(ADDR_OPTION, d); chk(d & 16'h0001, 16'h0001);
      wr_reg(ADDR_OPTION, 16'h0000);
      rd_reg(ADDR_OPTION, d); chk(d & 16'h0001, 16'h0000);
      i_src.pulse(0, 2);
      repeat (6) @(posedge ref_clk_in);
      n_wrap = n_ovf - c0;
      rd_reg(ADDR_CCR0, d);
      w = n_wrap * 32'h0001_0000 + int'(d);
      n = last_cc[0] - s0;
      chk({15'h0, w == n - 1 || w == n}, 16'h0001);
      chk(16'(n_wrap), 16'h0001);
      $display("test overflow done");
   endtask

   task automatic t_free();
      logic [15:0] d;
      logic [15:0] cap;
      logic [15:0] v1;
      logic [15:0] per;
      logic [16:0] nxt;
      logic        t2;
      int          c2;
      int          c3;
      int          s2;
      per = 16'h0011;
      wr_reg(ADDR_CTRL, 16'h0000);
      wr_reg(ADDR_CCR0 + 4'h2, per - 16'h0001);
      wr_reg(ADDR_OPTION, 16'h0080);
      wr_reg(ADDR_EDGE, {8'h00, EDGE_BOTH, 6'h00});
      t2 = tout[2];
      c2 = n_cc[2];
      c3 = n_cc[3];
      wr_reg(ADDR_CTRL, {8'h0, 1'b1, 4'h0, MODE_FREE_RUN});
      repeat (2) @(posedge ref_clk_in);
      #1 chk({15'h0, tout[2]}, {15'h0, ~t2});
      for (int i = 0; i < 100 && n_cc[2] == c2; i++) @(posedge ref_clk_in);
      @(posedge ref_clk_in);
      #1 chk({15'h0, tout[2]}, {15'h0, t2});
      chk(16'(n_cc[2] - c2), 16'h0001);
      s2 = last_cc[2];
      // Software moves the compare point on by one period, wrapping past FFFFH.
      nxt = {1'b0, per - 16'h0001} + {1'b0, per};
      if (nxt > 17'h0_FFFF) begin
         nxt = nxt - 17'h1_0000;
      end
      wr_reg(ADDR_CCR0 + 4'h2, nxt[15:0]);
      fork
         i_src.pulse(3, 12);
         begin
            wait (n_cc[3] != c3);
            rd_reg(ADDR_CCR0 + 4'h3, v1);
         end
      join
      repeat (8) @(posedge ref_clk_in);
      chk(16'(n_cc[3] - c3), 16'h0002);
      rd_reg(ADDR_CCR0 + 4'h3, cap);
      chk(cap - v1, 16'h000C);
      rd_reg(ADDR_COUNT, d);
      chk({15'h0, d > cap && cap > 16'h0010}, 16'h0001);
      chk(16'(n_cc[2] - c2), 16'h0002);
      chk(16'(last_cc[2] - s2), per);
      chk({15'h0, tout[2]}, {15'h0, ~t2});
      $display("test free running done");
   endtask

   task automatic end_sim();
      $display("tests=%0d mismatches=%0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge ref_clk_in);
      srst_in <= 1'b0;
      t_reset();
      t_pw();
      t_ovf();
      t_free();
      end_sim();
   end

   // Whole run is about 66k cycles; this limit sits well above it.
   initial begin
      #1_000_000;
      bad_count++;
      end_sim();
   end
endmodule
